// *** inc/pac_consts.svh ***
// constants of the process alarm and output control block
// included by the package; holds defines only
`ifndef PAC_CONSTS_SVH
`define PAC_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets, channel block numbers (address bits 7:4) and in-block word offsets (bits 3:2)
// ----------------------------------------------------------------
`define PAC_A_CTRL      8'h00
`define PAC_A_HPER      8'h04
`define PAC_A_CPER      8'h08
`define PAC_A_GAIN      8'h0C
`define PAC_A_STAT      8'h10
`define PAC_A_DP        8'h14
`define PAC_A_ISTAT     8'h18
`define PAC_A_IMASK     8'h1C
`define PAC_A_CH_FIRST  4'h2
`define PAC_A_CH_LAST   4'h4
`define PAC_O_TYPE      2'h0
`define PAC_O_VAL       2'h1
`define PAC_O_HYS       2'h2
`define PAC_O_CFG       2'h3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PAC_B_DIRECT    0
`define PAC_B_COOL      1
`define PAC_B_ASSIGN    0
`define PAC_B_OPEN      1
`define PAC_B_PER_EV    3
`define PAC_B_MV_LSB    8

// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define PAC_NCH         3
`define PAC_IRQ_W       4
`define PAC_R_HPER      8'h14
`define PAC_R_CPER      8'h14
`define PAC_R_GAIN      8'h10
`define PAC_R_DP        2'h0
`define PAC_R_TYPE      4'h2
`define PAC_R_VAL       16'h0000
`define PAC_R_HYS       16'h0002
`define PAC_GAIN_SHIFT  4
`define PAC_MV_MAX      100

// ----------------------------------------------------------------
// timing: periods are counted in 10 ms slots
// ----------------------------------------------------------------
`define PAC_CLK_NS      4
`define PAC_SLOT_NS     10000000
`define PAC_SLOTS_PER_S 100

`endif

// *** inc/pac_pkg.sv ***
// types of the process alarm and output control block
// constants live in pac_consts.svh
`include "pac_consts.svh"

package pac_pkg;

  typedef enum logic [1:0] {PAC_BUS_IDLE, PAC_BUS_WR, PAC_BUS_RD} pac_bus_t;

  typedef enum logic [2:0] {PAC_K_NONE, PAC_K_UP, PAC_K_LO, PAC_K_BOTH, PAC_K_BAND} pac_kind_t;

  typedef struct packed {
    logic alarm;
    logic standby;
  } pac_ch_state_t;

  typedef struct packed {
    pac_bus_t                          bus;
    logic [7:0]                        baddr;
    logic [31:0]                       rdata;
    logic                              direct;
    logic                              cool_en;
    logic [1:0][7:0]                   per;
    logic [7:0]                        gain;
    logic [1:0]                        dp;
    logic [`PAC_IRQ_W-1:0]             istat;
    logic [`PAC_IRQ_W-1:0]             imask;
    logic [`PAC_NCH-1:0][3:0]          atype;
    logic [`PAC_NCH-1:0][15:0]         aval;
    logic [`PAC_NCH-1:0][15:0]         ahys;
    logic [`PAC_NCH-1:0]               asgn;
    logic [`PAC_NCH-1:0]               opn;
    logic [`PAC_NCH-1:0]               restart;
    logic [`PAC_NCH-1:0]               alarm_prev;
    logic [31:0]                       pre;
    logic [1:0][15:0]                  pos;
    logic [1:0][15:0]                  duty;
    logic [1:0]                        pulse;
    logic signed [7:0]                 mv;
  } pac_top_state_t;

endpackage

// *** verilog/pac_alarm_ch.sv ***
// one alarm channel: type decode, hysteresis, standby, contact polarity
// inputs come from logic on mclk_i; tick_i is a one-cycle sample strobe
`timescale 1ns/1ps

module pac_alarm_ch (
  // clock and reset
  input  wire logic                mclk_i,
  input  wire logic                srst_i,
  // sampling
  input  wire logic                tick_i,
  input  wire logic                restart_i,
  input  wire logic signed [15:0]  process_value_i,
  input  wire logic signed [15:0]  set_point_i,
  // settings
  input  wire logic [3:0]          type_i,
  input  wire logic signed [15:0]  value_i,
  input  wire logic [15:0]         hyst_i,
  input  wire logic                assigned_i,
  input  wire logic                open_i,
  // results
  output logic                     alarm_o,
  output logic                     relay_o,
  output logic                     lamp_o
);

  pac_pkg::pac_ch_state_t st_q, st_d;
  pac_pkg::pac_kind_t     kind;
  logic                   dev, sb, region;
  logic signed [17:0]     q, x, h, lo_t;

  always_comb begin
    st_d = st_q;
    dev  = 1'b0;
    sb   = 1'b0;
    kind = pac_pkg::PAC_K_NONE;
    unique case (type_i)
      4'h1, 4'h5: begin dev = 1'b1; kind = pac_pkg::PAC_K_BOTH; end
      4'h2, 4'h6: begin dev = 1'b1; kind = pac_pkg::PAC_K_UP;   end
      4'h3, 4'h7: begin dev = 1'b1; kind = pac_pkg::PAC_K_LO;   end
      4'h4:       begin dev = 1'b1; kind = pac_pkg::PAC_K_BAND; end
      4'h8, 4'hA: kind = pac_pkg::PAC_K_UP;
      4'h9, 4'hB: kind = pac_pkg::PAC_K_LO;
      default:    kind = pac_pkg::PAC_K_NONE;
    endcase
    sb = (type_i >= 4'h5 && type_i <= 4'h7) || type_i == 4'hA || type_i == 4'hB;
    // deviation compares pv - sp, absolute compares pv itself
    q    = dev ? (18'(process_value_i) - 18'(set_point_i)) : 18'(process_value_i);
    x    = 18'(value_i);
    h    = $signed({2'b00, hyst_i});
    lo_t = dev ? -x : x;
    // an active alarm widens its region by h so it drops only past it
    unique case (kind)
      pac_pkg::PAC_K_UP:   region = st_q.alarm ? (q > x - h) : (q > x);
      pac_pkg::PAC_K_LO:   region = st_q.alarm ? (q < lo_t + h) : (q < lo_t);
      pac_pkg::PAC_K_BOTH: begin
        if (x < 0) region = (type_i == 4'h1);
        else       region = st_q.alarm ? (q > x - h || q < h - x) : (q > x || q < -x);
      end
      pac_pkg::PAC_K_BAND: begin
        if (x < 0) region = 1'b0;
        else       region = st_q.alarm ? (q >= -x - h && q <= x + h) : (q >= -x && q <= x);
      end
      default:             region = 1'b0;
    endcase
    if (tick_i) begin
      // standby holds off until the value has once left the region
      if (st_q.standby && !region) st_d.standby = 1'b0;
      st_d.alarm = region && !(sb && st_q.standby);
    end
    if (restart_i) begin
      st_d.standby = 1'b1;
      st_d.alarm   = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_q.alarm   <= 1'b0;
      st_q.standby <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign alarm_o = st_q.alarm;
  assign lamp_o  = st_q.alarm;
  assign relay_o = assigned_i && (st_q.alarm ^ open_i);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  sequence s_rearm;
    restart_i && sb;
  endsequence

  AST_TICK_ONLY: assert property (!tick_i && !restart_i |=> $stable(alarm_o))
    else $error("alarm changed without a sample tick");
  AST_NEG_T1: assert property (tick_i && !restart_i && type_i == 4'h1 && value_i < 0 |=> alarm_o)
    else $error("type 1 with negative value not asserted");
  AST_NEG_BAND: assert property ((type_i == 4'h4 || type_i == 4'h5) && value_i < 0 && tick_i |=> !alarm_o)
    else $error("band type with negative value asserted");
  AST_STANDBY: assert property (s_rearm ##1 (tick_i && region) |=> !alarm_o)
    else $error("standby did not hold the alarm off");
  AST_POLARITY: assert property (assigned_i |-> (relay_o == (lamp_o != open_i)))
    else $error("relay polarity does not match lamp");
  AST_HYST: assert property (tick_i && !restart_i && alarm_o && kind == pac_pkg::PAC_K_UP && q > x - h
                             |=> alarm_o)
    else $error("alarm dropped inside hysteresis band");

endmodule

// *** verilog/pac_top.sv ***
// process alarm and output control: direction, time-proportional outputs,
// three alarm channels, AHB-Lite register slave, one interrupt line.
// process_value_i, set_point_i and sample_tick_i come from logic on mclk_i.
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "pac_consts.svh"

// Behaviour
// - direct: output rises as process value rises
// - heating is reverse, cooling is direct
// - pulse train period is heat period, default 20s
// - cool period locked unless cooling assigned
// - three channels, relay only when assigned
// - per-channel type code, default 2, deviation kinds
// - types 8-11 absolute limits, 10-11 standby
// - negative value: type1 always on, 4/5 off
// - per-channel signed alarm value, default zero
// - per-channel hysteresis, default 0.02 percent span
// - standby: suppress until region left once
// - polarity inverts relay, lamp follows alarm
// - alarm value uses input decimal point; dp is only stored and read back, not applied to the alarm value
// - polarity set per channel, apart from type
module pac_top #(
  parameter int unsigned SLOT_CYCLES = `PAC_SLOT_NS / `PAC_CLK_NS
) (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 srst_i,
  // AHB-Lite slave
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  output logic [31:0]               hrdata_o,
  // measurement side
  input  wire logic                 sample_tick_i,
  input  wire logic signed [15:0]   process_value_i,
  input  wire logic signed [15:0]   set_point_i,
  // outputs
  output logic                      heat_out_o,
  output logic                      cool_out_o,
  output logic [`PAC_NCH-1:0]       alarm_relay_o,
  output logic [`PAC_NCH-1:0]       alarm_lamp_o,
  output logic                      irq_o
);

  pac_pkg::pac_top_state_t st_q, st_d;
  logic [`PAC_NCH-1:0]     alarm;
  logic                    slot;
  logic [1:0][15:0]        pslots;
  logic [1:0][15:0]        duty_new;
  logic [`PAC_IRQ_W-1:0]   ev;
  logic signed [16:0]      err;
  logic signed [25:0]      prod, sc;
  logic [7:0]              mv_pos, mv_neg;
  logic [1:0]              ch_sel;
  logic                    ch_hit;

  // ----------------------------------------------------------------
  // alarm channels
  // ----------------------------------------------------------------
  for (genvar c = 0; c < `PAC_NCH; c++) begin : g_ch
    pac_alarm_ch u_ch (
      .mclk_i          (mclk_i),
      .srst_i          (srst_i),
      .tick_i          (sample_tick_i),
      .restart_i       (st_q.restart[c]),
      .process_value_i (process_value_i),
      .set_point_i     (set_point_i),
      .type_i          (st_q.atype[c]),
      .value_i         ($signed(st_q.aval[c])),
      .hyst_i          (st_q.ahys[c]),
      .assigned_i      (st_q.asgn[c]),
      .open_i          (st_q.opn[c]),
      .alarm_o         (alarm[c]),
      .relay_o         (alarm_relay_o[c]),
      .lamp_o          (alarm_lamp_o[c])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    st_d.restart = '0;
    ch_sel     = 2'(st_q.baddr[7:4] - `PAC_A_CH_FIRST);
    ch_hit     = st_q.baddr[7:4] >= `PAC_A_CH_FIRST && st_q.baddr[7:4] <= `PAC_A_CH_LAST;

    // bus: reads take one wait cycle so a write just before is seen
    unique case (st_q.bus)
      pac_pkg::PAC_BUS_WR: begin
        st_d.bus = pac_pkg::PAC_BUS_IDLE;
        if (ch_hit) begin
          unique case (st_q.baddr[3:2])
            `PAC_O_TYPE: begin
              st_d.atype[ch_sel]   = hwdata_i[3:0];
              st_d.restart[ch_sel] = 1'b1;
            end
            `PAC_O_VAL:  st_d.aval[ch_sel] = hwdata_i[15:0];
            `PAC_O_HYS:  st_d.ahys[ch_sel] = hwdata_i[15:0];
            `PAC_O_CFG: begin
              st_d.asgn[ch_sel] = hwdata_i[`PAC_B_ASSIGN];
              st_d.opn[ch_sel]  = hwdata_i[`PAC_B_OPEN];
            end
          endcase
        end else begin
          unique case (st_q.baddr)
            `PAC_A_CTRL: begin
              st_d.direct  = hwdata_i[`PAC_B_DIRECT];
              st_d.cool_en = hwdata_i[`PAC_B_COOL];
            end
            `PAC_A_HPER:  st_d.per[0] = hwdata_i[7:0];
            `PAC_A_CPER:  if (st_q.cool_en) st_d.per[1] = hwdata_i[7:0];
            `PAC_A_GAIN:  st_d.gain  = hwdata_i[7:0];
            `PAC_A_DP:    st_d.dp    = hwdata_i[1:0];
            `PAC_A_IMASK: st_d.imask = hwdata_i[`PAC_IRQ_W-1:0];
            default: ;
          endcase
        end
      end
      pac_pkg::PAC_BUS_RD: begin
        st_d.bus   = pac_pkg::PAC_BUS_IDLE;
        st_d.rdata = '0;
        if (ch_hit) begin
          unique case (st_q.baddr[3:2])
            `PAC_O_TYPE: st_d.rdata = 32'(st_q.atype[ch_sel]);
            `PAC_O_VAL:  st_d.rdata = 32'(st_q.aval[ch_sel]);
            `PAC_O_HYS:  st_d.rdata = 32'(st_q.ahys[ch_sel]);
            `PAC_O_CFG:  st_d.rdata = 32'({st_q.opn[ch_sel], st_q.asgn[ch_sel]});
          endcase
        end else begin
          unique case (st_q.baddr)
            `PAC_A_CTRL:  st_d.rdata = 32'({st_q.cool_en, st_q.direct});
            `PAC_A_HPER:  st_d.rdata = 32'(st_q.per[0]);
            `PAC_A_CPER:  st_d.rdata = 32'(st_q.per[1]);
            `PAC_A_GAIN:  st_d.rdata = 32'(st_q.gain);
            `PAC_A_STAT:  st_d.rdata = 32'({st_q.mv, 3'h0, st_q.pulse, alarm});
            `PAC_A_DP:    st_d.rdata = 32'(st_q.dp);
            `PAC_A_ISTAT: st_d.rdata = 32'(st_q.istat);
            `PAC_A_IMASK: st_d.rdata = 32'(st_q.imask);
            default:      st_d.rdata = '0;
          endcase
        end
      end
      pac_pkg::PAC_BUS_IDLE: ;
    endcase
    if (st_q.bus != pac_pkg::PAC_BUS_RD && hsel_i && hready_i && htrans_i[1]) begin
      st_d.bus   = hwrite_i ? pac_pkg::PAC_BUS_WR : pac_pkg::PAC_BUS_RD;
      st_d.baddr = haddr_i[7:0];
    end

    // manipulated variable, direction picks the sign of the error
    err  = st_q.direct ? 17'(process_value_i) - 17'(set_point_i)
                       : 17'(set_point_i) - 17'(process_value_i);
    prod = 26'(err) * $signed(26'(st_q.gain));
    sc   = prod >>> `PAC_GAIN_SHIFT;
    if (sample_tick_i) begin
      if (sc > $signed(26'(`PAC_MV_MAX)))       st_d.mv = 8'(`PAC_MV_MAX);
      else if (sc < -$signed(26'(`PAC_MV_MAX))) st_d.mv = -8'(`PAC_MV_MAX);
      else                                       st_d.mv = 8'(sc);
    end

    // time-proportional outputs: positive part heats, negative part cools
    mv_pos      = st_q.mv > 0 ? 8'(st_q.mv) : 8'h00;
    mv_neg      = (st_q.cool_en && st_q.mv < 0) ? 8'(-st_q.mv) : 8'h00;
    duty_new[0] = 16'(mv_pos) * 16'(st_q.per[0]);
    duty_new[1] = 16'(mv_neg) * 16'(st_q.per[1]);
    slot        = st_q.pre == 32'(SLOT_CYCLES - 1);
    st_d.pre    = slot ? 32'h0000_0000 : st_q.pre + 32'h0000_0001;
    ev          = '0;
    for (int i = 0; i < 2; i++) begin
      pslots[i] = 16'(st_q.per[i]) * 16'(`PAC_SLOTS_PER_S);
      if (slot) begin
        // duty is latched at the period start to keep each pulse whole
        if (pslots[i] == 16'h0000 || st_q.pos[i] >= pslots[i] - 16'h0001) begin
          st_d.pos[i]  = 16'h0000;
          st_d.duty[i] = duty_new[i];
          if (i == 0) ev[`PAC_B_PER_EV] = 1'b1;
        end else begin
          st_d.pos[i] = st_q.pos[i] + 16'h0001;
        end
      end
      st_d.pulse[i] = st_d.pos[i] < st_d.duty[i];
    end

    // interrupts: a new event wins over a write-one clear
    ev[`PAC_NCH-1:0] = alarm & ~st_q.alarm_prev;
    st_d.alarm_prev  = alarm;
    if (st_q.bus == pac_pkg::PAC_BUS_WR && st_q.baddr == `PAC_A_ISTAT) begin
      st_d.istat = st_q.istat & ~hwdata_i[`PAC_IRQ_W-1:0];
    end
    st_d.istat = st_d.istat | ev;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_q         <= '0;
      st_q.per     <= {`PAC_R_CPER, `PAC_R_HPER};
      st_q.gain    <= `PAC_R_GAIN;
      st_q.dp      <= `PAC_R_DP;
      st_q.atype   <= {`PAC_NCH{`PAC_R_TYPE}};
      st_q.aval    <= {`PAC_NCH{`PAC_R_VAL}};
      st_q.ahys    <= {`PAC_NCH{`PAC_R_HYS}};
    end else begin
      st_q <= st_d;
    end
  end

  assign hreadyout_o = st_q.bus != pac_pkg::PAC_BUS_RD;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = st_q.rdata;
  assign heat_out_o  = st_q.pulse[0];
  assign cool_out_o  = st_q.pulse[1];
  assign irq_o       = |(st_q.istat & st_q.imask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  AST_COOL_LOCK: assert property (st_q.bus == pac_pkg::PAC_BUS_WR && st_q.baddr == `PAC_A_CPER && !st_q.cool_en
                                  |=> $stable(st_q.per[1]))
    else $error("cool period changed while cooling unassigned");
  AST_DIRECT: assert property (sample_tick_i && st_q.direct && process_value_i > set_point_i |=> st_q.mv >= 0)
    else $error("direct action gave negative output");
  AST_REVERSE: assert property (sample_tick_i && !st_q.direct && process_value_i < set_point_i
                                |=> st_q.mv >= 0)
    else $error("reverse action gave negative output");
  AST_PERIOD: assert property (slot && pslots[0] != 16'h0000 && st_q.pos[0] == pslots[0] - 16'h0001
                               |=> st_q.pos[0] == 16'h0000 && st_q.duty[0] == $past(duty_new[0]))
    else $error("heat period did not wrap");
  AST_DUTY: assert property (heat_out_o == (st_q.pos[0] < st_q.duty[0]))
    else $error("heat pulse does not match duty");

endmodule

// *** test/pac_out_model.sv ***
// output unit model: counts on-time of the heat and cool pulse lines
// assumes the pulse lines are registered on mclk_i
`timescale 1ns/1ps

module pac_out_model (
  input  wire logic        mclk_i,
  input  wire logic        win_i,
  input  wire logic        heat_i,
  input  wire logic        cool_i,
  output logic [15:0]      heat_cnt_o,
  output logic [15:0]      cool_cnt_o
);
  // counts restart whenever the window is closed
  always @(posedge mclk_i) begin
    if (win_i !== 1'b1) begin
      heat_cnt_o <= 16'h0000;
      cool_cnt_o <= 16'h0000;
    end else begin
      heat_cnt_o <= heat_cnt_o + {15'h0000, heat_i};
      cool_cnt_o <= cool_cnt_o + {15'h0000, cool_i};
    end
  end
endmodule

// *** test/pac_top_tb.sv ***
// self-checking bench for the alarm and output control block
// assumes a single AHB-Lite master and hready tied to hreadyout
`timescale 1ns/1ps
`include "pac_consts.svh"

module pac_top_tb;
  localparam int SLOT = 4;
  logic               mclk_i, srst_i, hsel, hwrite, tick, win, rd_ph;
  logic [1:0]         htrans, probe;
  logic [31:0]        haddr, hwdata, hrdata, rv;
  logic               hrdy, hresp, heat, cool, irq;
  logic [2:0]         relay, lamp;
  logic signed [15:0] pv, sp;
  logic [15:0]        hcnt, ccnt;
  logic [63:0]        expq[$];
  logic [63:0]        e;
  logic [47:0]        mvt [5];
  int                 mismatches, compares, seed, i;

  pac_top #(.SLOT_CYCLES(SLOT)) i_pac_top (.mclk_i(mclk_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .sample_tick_i(tick), .process_value_i(pv),
    .set_point_i(sp), .heat_out_o(heat), .cool_out_o(cool), .alarm_relay_o(relay), .alarm_lamp_o(lamp),
    .irq_o(irq));
  pac_out_model i_pac_out_model (.mclk_i(mclk_i), .win_i(win), .heat_i(heat), .cool_i(cool),
    .heat_cnt_o(hcnt), .cool_cnt_o(ccnt));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // takes the oldest note whenever a read completes or a probe fires
  always @(posedge mclk_i) begin
    if ((rd_ph === 1'b1 && hrdy === 1'b1) || probe != 2'h0) begin
      e = expq.pop_front();
      if (probe == 2'h1) check({25'h0, irq, relay, lamp}, e[31:0]);
      else if (probe == 2'h2) check({hcnt, ccnt}, e[31:0]);
      else begin
        check(hrdata & e[63:32], e[31:0]);
        check({31'h0, hresp}, 32'h0);
      end
    end
  end

  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= ~wr;
    if (!wr) expq.push_back({m, d});
    wait_rdy();
    rd_ph <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFFFFFF);
    bus(1'b0, a, x, m);
  endtask

  function automatic logic [7:0] ca(input int n, input logic [7:0] o);
    return 8'h20 + 8'(n * 16) + o;
  endfunction

  task automatic probe_out(input logic [31:0] x, input logic [1:0] k);
    expq.push_back({32'hFFFFFFFF, x});
    probe <= k;
    @(posedge mclk_i);
    probe <= 2'h0;
  endtask

  task automatic smp(input logic signed [15:0] p, input logic signed [15:0] s);
    // idle edge first: a tick in the re-arm cycle of a type write is overridden
    @(posedge mclk_i);
    pv <= p;
    sp <= s;
    tick <= 1'b1;
    @(posedge mclk_i);
    tick <= 1'b0;
    @(posedge mclk_i);
  endtask

  // probe vector is {irq, relay[2:0], lamp[2:0]}
  task automatic tk(input logic signed [15:0] p, input logic signed [15:0] s, input logic [6:0] x);
    smp(p, s);
    probe_out({25'h0, x}, 2'h1);
  endtask

  // windows span two whole periods, so the phase does not matter
  task automatic pulse_win(input logic [31:0] x);
    repeat (450) @(posedge mclk_i);
    win <= 1'b1;
    repeat (800) @(posedge mclk_i);
    win <= 1'b0;
    probe_out(x, 2'h2);
  endtask

  initial begin
    seed = 61519;
    mvt = '{48'h00_0000_0028_28, 48'h01_0028_0000_28, 48'h00_0028_0000_D8, 48'h01_0000_0028_D8,
            48'h00_0000_00C8_64};
    {srst_i, hsel, hwrite, tick, win, rd_ph} = 6'h20;
    {htrans, probe, haddr, hwdata, pv, sp} = '0;
    mismatches = 0;
    compares = 0;
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rd(`PAC_A_CTRL, 32'h0);
    rd(`PAC_A_HPER, 32'h14);
    rd(`PAC_A_CPER, 32'h14);
    rd(`PAC_A_GAIN, 32'h10);
    rd(`PAC_A_IMASK, 32'h0);
    rd(8'hF0, 32'h0);
    for (i = 0; i < 3; i++) begin
      rd(ca(i, 8'h0), 32'h2);
      rd(ca(i, 8'h4), 32'h0);
      rd(ca(i, 8'h8), 32'h2);
      rd(ca(i, 8'hC), 32'h0);
    end
    rv = $random(seed);
    wr(ca(1, 8'h0), 32'h0);
    wr(ca(1, 8'h4), {16'h0, rv[15:0]});
    wr(ca(1, 8'h8), {16'h0, rv[31:16]});
    wr(ca(1, 8'hC), 32'h2);
    rd(ca(1, 8'h4), {16'h0, rv[15:0]});
    rd(ca(1, 8'h8), {16'h0, rv[31:16]});
    rd(ca(1, 8'hC), 32'h2);
    rd(ca(1, 8'h0), 32'h0);
    wr(`PAC_A_CPER, 32'h5);
    rd(`PAC_A_CPER, 32'h14);
    wr(`PAC_A_CTRL, 32'h2);
    wr(`PAC_A_CPER, 32'h1);
    rd(`PAC_A_CPER, 32'h1);
    wr(`PAC_A_DP, 32'h1);
    rd(`PAC_A_DP, 32'h1);
    wr(`PAC_A_CTRL, 32'h0);
    wr(`PAC_A_IMASK, 32'h1);
    wr(ca(0, 8'h8), 32'hA);
    wr(ca(0, 8'h4), 32'h64);
    wr(ca(0, 8'hC), 32'h3);
    wr(ca(0, 8'h0), 32'h8);
    tk(16'sd101, 16'sd200, 7'h41);
    tk(16'sd95, 16'sd200, 7'h41);
    tk(16'sd90, 16'sd200, 7'h48);
    wr(`PAC_A_ISTAT, 32'h1);
    probe_out(32'h08, 2'h1);
    wr(`PAC_A_IMASK, 32'h0);
    wr(ca(0, 8'hC), 32'h0);
    tk(16'sd101, 16'sd200, 7'h01);
    wr(`PAC_A_IMASK, 32'h1);
    probe_out(32'h41, 2'h1);
    wr(`PAC_A_IMASK, 32'h0);
    wr(ca(0, 8'h4), 32'hFFCE);
    wr(ca(0, 8'h0), 32'h9);
    tk(-16'sd51, 16'sd200, 7'h01);
    tk(-16'sd45, 16'sd200, 7'h01);
    tk(-16'sd40, 16'sd200, 7'h00);
    wr(ca(0, 8'h4), 32'hFFFB);
    wr(ca(0, 8'h0), 32'h1);
    tk(16'sd0, 16'sd0, 7'h01);
    wr(ca(0, 8'h0), 32'h4);
    tk(16'sd0, 16'sd0, 7'h00);
    wr(ca(0, 8'h0), 32'h5);
    tk(16'sd0, 16'sd0, 7'h00);
    wr(ca(2, 8'h8), 32'hA);
    wr(ca(2, 8'h4), 32'h14);
    wr(ca(2, 8'h0), 32'h7);
    tk(16'sd100, 16'sd200, 7'h00);
    tk(16'sd200, 16'sd200, 7'h00);
    tk(16'sd100, 16'sd200, 7'h04);
    wr(ca(2, 8'h0), 32'h3);
    tk(16'sd100, 16'sd200, 7'h04);
    wr(ca(0, 8'h4), 32'h64);
    wr(ca(0, 8'h0), 32'hA);
    tk(16'sd150, 16'sd0, 7'h00);
    tk(16'sd50, 16'sd0, 7'h00);
    tk(16'sd150, 16'sd0, 7'h01);
    for (i = 0; i < 5; i++) begin
      wr(`PAC_A_CTRL, {24'h0, mvt[i][47:40]});
      smp(mvt[i][39:24], mvt[i][23:8]);
      rd(`PAC_A_STAT, {16'h0, mvt[i][7:0], 8'h00}, 32'h0000FF00);
    end
    wr(`PAC_A_HPER, 32'h1);
    wr(`PAC_A_CTRL, 32'h0);
    smp(16'sd0, 16'sd40);
    pulse_win({16'h0140, 16'h0000});
    wr(`PAC_A_CTRL, 32'h2);
    smp(16'sd40, 16'sd0);
    pulse_win({16'h0000, 16'h0140});
    rd(`PAC_A_ISTAT, 32'h8, 32'h8);
    final_report();
  end
endmodule
